// [hw/ctp_regs.svh]
// Register offsets, field positions, reset values and prescale counts of the timer pairs.
`ifndef CTP_REGS_SVH
`define CTP_REGS_SVH

`define CTP_NUM_TIMERS   8
`define CTP_NUM_PAIRS    4

// Per-timer window: timer i occupies byte addresses i*16 .. i*16+15.
`define CTP_OFF_CTRL     4'h0
`define CTP_OFF_PERIOD   4'h4
`define CTP_OFF_COUNT    4'h8
`define CTP_OFF_STATUS   8'h80
`define CTP_OFF_MASK     8'h84
`define CTP_OFF_PRIO     8'h88

// Control word fields.
`define CTP_BIT_ON       15
`define CTP_BIT_GATE     6
`define CTP_BIT_PS_HI    5
`define CTP_BIT_PS_LO    4
`define CTP_BIT_JOIN     3
`define CTP_BIT_CS       1

// Priority field: three bits per timer, one nibble per timer.
`define CTP_PRIO_STRIDE  4
`define CTP_PRIO_OFF     3'h0

`define CTP_RST_PERIOD   16'hffff
`define CTP_RST_COUNT    16'h0000
`define CTP_RST_PRIO     3'h4

// Prescale terminal counts: ratios 1, 8, 64 and 256.
`define CTP_PS_LIM0      8'h00
`define CTP_PS_LIM1      8'h07
`define CTP_PS_LIM2      8'h3f
`define CTP_PS_LIM3      8'hff

`endif

// [hw/ctp_pkg.sv]
// Types shared by the timer pair design.
package ctp_pkg;

   typedef struct packed {
      logic       timer_on;
      logic       pair_join_bit;
      logic       gate_enable;
      logic [1:0] prescale_select;
      logic       clock_source_select;
   } ctp_ctrl_t;

   typedef struct packed {
      logic [15:0] count_lo;
      logic [15:0] count_hi;
      logic        match_lo;
      logic        match_hi;
   } ctp_timebase_t;

endpackage

// [hw/ctp_tick_gen.sv]
// Count-clock generator of one 16-bit timer: source select, gating and prescaler.
`timescale 1ns/1ps
`include "ctp_regs.svh"

module ctp_tick_gen
   import ctp_pkg::*;
(
   input  wire logic      hclk,
   input  wire logic      hresetn,
   input  wire ctp_ctrl_t ctrl,
   input  wire logic      ext_in,
   input  wire logic      gate_in,
   output logic           tick
);

   logic [7:0] pre_q;
   logic [7:0] lim;
   logic       ext_q;
   logic       src;

   always_comb begin
      case (ctrl.prescale_select)
         2'h0:    lim = `CTP_PS_LIM0;
         2'h1:    lim = `CTP_PS_LIM1;
         2'h2:    lim = `CTP_PS_LIM2;
         default: lim = `CTP_PS_LIM3;
      endcase
   end

   // External pulses count on their rising edge; gating only qualifies the internal clock.
   assign src  = ctrl.clock_source_select ? (ext_in & ~ext_q) : (~ctrl.gate_enable | gate_in);
   // A ratio lowered while running can leave the prescaler above its new limit; treat that as terminal.
   assign tick = ctrl.timer_on & src & (pre_q >= lim);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= ext_in;
      end
   end

   // Clearing on timer-off restarts the ratio cleanly when the timer is re-enabled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_q <= 8'h00;
      end else if (!ctrl.timer_on) begin
         pre_q <= 8'h00;
      end else if (src) begin
         pre_q <= (pre_q >= lim) ? 8'h00 : pre_q + 8'h01;
      end
   end

endmodule // ctp_tick_gen

// [hw/ctp_timer_pairs.sv]
// Four cascadable pairs of 16-bit timers with an AHB-Lite register slave.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ctp_regs.svh"

module ctp_timer_pairs
   import ctp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  ext_count_in,
   input  wire logic [7:0]  gate_in,
   output logic             irq_q,
   output logic [2:0]       irq_level_q,
   output logic [1:0]       adc_trig_q,
   output ctp_timebase_t    timebase_q
);

   // ==========================================================================
   // State
   // ==========================================================================

   ctp_ctrl_t   ctrl_q   [`CTP_NUM_TIMERS];
   logic [15:0] period_q [`CTP_NUM_TIMERS];
   logic [15:0] cnt_q    [`CTP_NUM_TIMERS];
   logic [15:0] cnt_d    [`CTP_NUM_TIMERS];
   logic [2:0]  prio_q   [`CTP_NUM_TIMERS];
   logic [7:0]  status_q;
   logic [7:0]  mask_q;
   logic [7:0]  tick;
   logic [7:0]  evt;
   logic [3:0]  pair_evt;
   logic [7:0]  pend;
   logic [2:0]  level_d;

   logic        ap_valid_q;
   logic        ap_write_q;
   logic [7:0]  ap_addr_q;
   logic        wr_en;
   logic        rd_step;
   logic        is_tmr;
   logic [2:0]  tmr_idx;
   logic [3:0]  tmr_reg;
   logic [31:0] rd_mux;

   // ==========================================================================
   // Count clocks
   // ==========================================================================

   // Every timer has its own tick source; in a joined pair only the even one is used.
   genvar gi;
   generate
      for (gi = 0; gi < `CTP_NUM_TIMERS; gi++) begin : g_tick
         ctp_tick_gen u_tick (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ctrl    (ctrl_q[gi]),
            .ext_in  (ext_count_in[gi]),
            .gate_in (gate_in[gi]),
            .tick    (tick[gi])
         );
      end
   endgenerate

   // ==========================================================================
   // Counters
   // ==========================================================================

   // The timers have no power-state input at all, so idle and sleep never stop them.
   always_comb begin
      int          e;
      int          o;
      logic        join_bit;
      logic        m32;
      logic [31:0] c32;
      logic [31:0] p32;
      logic [31:0] n32;
      e        = 0;
      o        = 0;
      join_bit = 1'b0;
      m32      = 1'b0;
      c32      = 32'h0000_0000;
      p32      = 32'h0000_0000;
      n32      = 32'h0000_0000;
      pair_evt = 4'h0;
      evt      = 8'h00;
      for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
         cnt_d[i] = cnt_q[i];
      end
      for (int p = 0; p < `CTP_NUM_PAIRS; p++) begin
         e        = 2 * p;
         o        = e + 1;
         join_bit = ctrl_q[e].pair_join_bit;
         c32      = {cnt_q[o], cnt_q[e]};
         p32      = {period_q[o], period_q[e]};
         m32      = join_bit & tick[e] & (c32 == p32);
         pair_evt[p] = m32;
         if (join_bit) begin
            // Even timer's controls run the pair; the odd timer's own controls are ignored.
            n32      = m32 ? 32'h0000_0000 : (tick[e] ? c32 + 32'h0000_0001 : c32);
            cnt_d[e] = n32[15:0];
            cnt_d[o] = n32[31:16];
            evt[o]   = m32;
         end else begin
            evt[e] = tick[e] & (cnt_q[e] == period_q[e]);
            evt[o] = tick[o] & (cnt_q[o] == period_q[o]);
            if (tick[e]) begin
               cnt_d[e] = evt[e] ? 16'h0000 : cnt_q[e] + 16'h0001;
            end
            if (tick[o]) begin
               cnt_d[o] = evt[o] ? 16'h0000 : cnt_q[o] + 16'h0001;
            end
         end
      end
      // A software write to a count register wins over counting in the same cycle.
      if (wr_en && is_tmr && tmr_reg == `CTP_OFF_COUNT) begin
         cnt_d[tmr_idx] = hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
            cnt_q[i] <= `CTP_RST_COUNT;
         end
      end else begin
         for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   // ==========================================================================
   // Converter triggers and time base
   // ==========================================================================

   // Only joined-pair matches reach the converters; separate halves never do.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         adc_trig_q <= 2'h0;
      end else begin
         adc_trig_q[0] <= pair_evt[0];
         adc_trig_q[1] <= pair_evt[1];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timebase_q <= '0;
      end else begin
         timebase_q.count_lo <= cnt_q[0];
         timebase_q.count_hi <= cnt_q[1];
         timebase_q.match_lo <= evt[0];
         timebase_q.match_hi <= evt[1];
      end
   end

   // ==========================================================================
   // AHB-Lite slave
   // ==========================================================================

   // Writes finish with no wait state. Reads take one wait state so that a read right after
   // a write always sees the written value.
   assign wr_en   = ap_valid_q & ap_write_q;
   assign rd_step = ap_valid_q & ~ap_write_q & ~hreadyout;
   assign is_tmr  = ~ap_addr_q[7];
   assign tmr_idx = ap_addr_q[6:4];
   assign tmr_reg = ap_addr_q[3:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q  <= 8'h00;
      end else if (hready && hreadyout) begin
         ap_valid_q <= hsel & htrans[1];
         ap_write_q <= hwrite;
         ap_addr_q  <= haddr[7:0];
      end else if (rd_step) begin
         ap_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (hready && hreadyout && hsel && htrans[1] && !hwrite) begin
         hreadyout <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (is_tmr) begin
         case (tmr_reg)
            `CTP_OFF_CTRL: begin
               rd_mux[`CTP_BIT_ON]                     = ctrl_q[tmr_idx].timer_on;
               rd_mux[`CTP_BIT_GATE]                   = ctrl_q[tmr_idx].gate_enable;
               rd_mux[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]   = ctrl_q[tmr_idx].prescale_select;
               rd_mux[`CTP_BIT_JOIN]                   = ctrl_q[tmr_idx].pair_join_bit;
               rd_mux[`CTP_BIT_CS]                     = ctrl_q[tmr_idx].clock_source_select;
            end
            `CTP_OFF_PERIOD: rd_mux[15:0] = period_q[tmr_idx];
            `CTP_OFF_COUNT:  rd_mux[15:0] = cnt_q[tmr_idx];
            default:         rd_mux = 32'h0000_0000;
         endcase
      end else begin
         case (ap_addr_q)
            `CTP_OFF_STATUS: rd_mux[7:0] = status_q;
            `CTP_OFF_MASK:   rd_mux[7:0] = mask_q;
            `CTP_OFF_PRIO: begin
               for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
                  rd_mux[i*`CTP_PRIO_STRIDE +: 3] = prio_q[i];
               end
            end
            default:         rd_mux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_step) begin
         hrdata <= rd_mux;
      end
   end

   // ==========================================================================
   // Configuration registers
   // ==========================================================================

   // Odd timers have no join bit; a pair is joined only through its even timer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
            ctrl_q[i] <= '0;
         end
      end else if (wr_en && is_tmr && tmr_reg == `CTP_OFF_CTRL) begin
         ctrl_q[tmr_idx].timer_on            <= hwdata[`CTP_BIT_ON];
         ctrl_q[tmr_idx].gate_enable         <= hwdata[`CTP_BIT_GATE];
         ctrl_q[tmr_idx].prescale_select     <= hwdata[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO];
         ctrl_q[tmr_idx].pair_join_bit       <= hwdata[`CTP_BIT_JOIN] & ~tmr_idx[0];
         ctrl_q[tmr_idx].clock_source_select <= hwdata[`CTP_BIT_CS];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
            period_q[i] <= `CTP_RST_PERIOD;
         end
      end else if (wr_en && is_tmr && tmr_reg == `CTP_OFF_PERIOD) begin
         period_q[tmr_idx] <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
            prio_q[i] <= `CTP_RST_PRIO;
         end
      end else if (wr_en && ap_addr_q == `CTP_OFF_PRIO) begin
         for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
            prio_q[i] <= hwdata[i*`CTP_PRIO_STRIDE +: 3];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= 8'h00;
      end else if (wr_en && ap_addr_q == `CTP_OFF_MASK) begin
         mask_q <= hwdata[7:0];
      end
   end

   // ==========================================================================
   // Interrupts
   // ==========================================================================

   // A new match in the clearing cycle keeps its flag set.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= 8'h00;
      end else if (wr_en && ap_addr_q == `CTP_OFF_STATUS) begin
         status_q <= (status_q & ~hwdata[7:0]) | evt;
      end else begin
         status_q <= status_q | evt;
      end
   end

   // A zero priority removes the source even when its enable bit is set.
   always_comb begin
      level_d = `CTP_PRIO_OFF;
      for (int i = 0; i < `CTP_NUM_TIMERS; i++) begin
         pend[i] = status_q[i] & mask_q[i] & (prio_q[i] != `CTP_PRIO_OFF);
         if (pend[i] && prio_q[i] > level_d) begin
            level_d = prio_q[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q       <= 1'b0;
         irq_level_q <= `CTP_PRIO_OFF;
      end else begin
         irq_q       <= |pend;
         irq_level_q <= level_d;
      end
   end

endmodule // ctp_timer_pairs

// [tb/ctp_timer_pairs_props.sv]
// Concurrent checks on the ports of the timer pair block.
`timescale 1ns/1ps

module ctp_timer_pairs_props
   import ctp_pkg::*;
(
   input wire logic          hclk,
   input wire logic          hresetn,
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [2:0]    hsize,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   input wire logic [31:0]   hrdata,
   input wire logic          hreadyout,
   input wire logic          hresp,
   input wire logic [7:0]    ext_count_in,
   input wire logic [7:0]    gate_in,
   input wire logic          irq_q,
   input wire logic [2:0]    irq_level_q,
   input wire logic [1:0]    adc_trig_q,
   input wire ctp_timebase_t timebase_q
);
   // =====================================================================
   // Bus and counter relations
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic take;
   assign take = hsel && htrans[1] && hready && hreadyout;

   bus_okay_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state not exactly one cycle");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write was stalled");
   irq_level_a: assert property (irq_q == (irq_level_q != 3'h0))
      else $error("interrupt line disagrees with pending level");
   adc0_source_a: assert property (adc_trig_q[0] |-> timebase_q.match_hi || $past(timebase_q.match_hi))
      else $error("first converter trigger without a high word match");
   lo_wrap_a: assert property (timebase_q.match_lo |=> timebase_q.count_lo == 16'h0)
      else $error("low timer flagged without returning to zero");
   hi_wrap_a: assert property (timebase_q.match_hi |=> timebase_q.count_hi == 16'h0)
      else $error("high timer flagged without returning to zero");
   lo_step_a: assert property (timebase_q.count_lo != $past(timebase_q.count_lo) |->
      timebase_q.count_lo == $past(timebase_q.count_lo) + 16'h1 || timebase_q.count_lo == 16'h0)
      else $error("low count jumped");
endmodule // ctp_timer_pairs_props

bind ctp_timer_pairs ctp_timer_pairs_props u_ctp_timer_pairs_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .ext_count_in(ext_count_in), .gate_in(gate_in), .irq_q(irq_q),
   .irq_level_q(irq_level_q), .adc_trig_q(adc_trig_q), .timebase_q(timebase_q));

// [tb/tb.sv]
// Self-checking bench of the timer pair block.
`timescale 1ns/1ps

module tb;
   import ctp_pkg::*;
   typedef struct {logic [31:0] a; logic wr; logic [31:0] wd; logic [31:0] ex;} ctp_row_t;

   logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_q;
   logic [31:0]   haddr, hwdata, hrdata, d;
   logic [1:0]    htrans, adc_trig_q;
   logic [2:0]    hsize, irq_level_q;
   logic [7:0]    ext_count_in, gate_in;
   ctp_timebase_t timebase_q;
   logic [15:0]   c0, mx;
   int            error_cnt, comparisons, n, lim, p;
   int            sh [4] = '{0, 3, 6, 8};
   // Reset values first, then field masks, unmapped place and priority nibbles.
   ctp_row_t      rows [13] = '{
      '{32'h00, 0, 0, 32'h0}, '{32'h04, 0, 0, 32'hffff}, '{32'h08, 0, 0, 32'h0},
      '{32'h80, 0, 0, 32'h0}, '{32'h84, 0, 0, 32'h0}, '{32'h88, 0, 0, 32'h44444444},
      '{32'h14, 1, 32'habcd1234, 32'h1234}, '{32'h10, 1, 32'h7a, 32'h72},
      '{32'h00, 1, 32'h7a, 32'h7a}, '{32'hfc, 1, 32'hffffffff, 32'h0},
      '{32'h88, 1, 32'h76543210, 32'h76543210}, '{32'h00, 1, 0, 0}, '{32'h10, 1, 0, 0}};

   assign hready = hreadyout;

   ctp_timer_pairs u_ctp_timer_pairs (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ext_count_in(ext_count_in), .gate_in(gate_in), .irq_q(irq_q),
      .irq_level_q(irq_level_q), .adc_trig_q(adc_trig_q), .timebase_q(timebase_q));

   // =====================================================================
   // Bus master and comparisons
   task automatic ahb_wr(input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task automatic ahb_rd(input logic [31:0] a, output logic [31:0] rd);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] ex);
      comparisons++;
      if (got !== ex) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, ex);
      end
   endtask

   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, wanted %h to %h", $time, got, lo, hi);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // =====================================================================
   // Clock, reset, watchdog
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   initial begin
      repeat (90000) @(posedge hclk);
      error_cnt++;
      final_report;
   end

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
      ext_count_in = 0; gate_in = 0; error_cnt = 0; comparisons = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i]) begin
         if (rows[i].wr) ahb_wr(rows[i].a, rows[i].wd);
         ahb_rd(rows[i].a, d);
         chk(d, rows[i].ex);
      end
      $display("register table done");
      // Timer0 alone, period 2, priority 0 first so the line must stay quiet.
      ahb_wr(32'h04, 32'h2); ahb_wr(32'h84, 32'h1); ahb_wr(32'h00, 32'h8000);
      mx = 0;
      repeat (12) begin
         @(posedge hclk);
         if (timebase_q.count_lo > mx) mx = timebase_q.count_lo;
      end
      chk({16'h0, mx}, 32'h2);
      chk({31'h0, irq_q}, 32'h0);
      ahb_rd(32'h80, d);
      chk(d & 32'h1, 32'h1);
      ahb_wr(32'h88, 32'h7);
      repeat (4) @(posedge hclk);
      chk({28'h0, irq_q, irq_level_q}, 32'hf);
      ahb_wr(32'h00, 32'h0); ahb_wr(32'h80, 32'h1);
      ahb_rd(32'h80, d);
      chk(d, 32'h0);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq_q}, 32'h0);
      $display("single timer done");
      // Joined pairs: pair 0 needs the high word, pairs 1 and 2 a short period.
      ahb_wr(32'h88, 32'h44444444); ahb_wr(32'h84, 32'haa);
      for (p = 0; p < 3; p++) begin
         ahb_wr(32'(p * 32 + 20), (p == 0) ? 32'h1 : 32'h0);
         ahb_wr(32'(p * 32 + 4), 32'h3);
         ahb_wr(32'(p * 32), 32'h0008);
         ahb_wr(32'(p * 32), 32'h8008);
         lim = (p == 0) ? 70000 : 40;
         n = 0;
         while (adc_trig_q === 2'h0 && n < lim) begin
            @(posedge hclk);
            n++;
         end
         chk({30'h0, adc_trig_q}, (p < 2) ? (32'h1 << p) : 32'h0);
         if (p == 0) chk_rng(n, 32'd65530, 32'd65560);
         ahb_rd(32'h80, d);
         chk((d >> (2 * p + 1)) & 32'h1, 32'h1);
         chk({31'h0, irq_q}, 32'h1);
         ahb_wr(32'(p * 32), 32'h0); ahb_wr(32'h80, 32'hff);
      end
      // Pair 3: a low word about to wrap must carry into the odd count register.
      ahb_wr(32'h68, 32'hfffe);
      ahb_wr(32'h60, 32'h0008);
      ahb_wr(32'h60, 32'h8008);
      repeat (2) @(posedge hclk);
      ahb_rd(32'h78, d);
      chk(d, 32'h1);
      ahb_rd(32'h68, d);
      chk_rng(d, 32'h3, 32'h5);
      ahb_wr(32'h60, 32'h0);
      $display("joined pairs done");
      ahb_wr(32'h04, 32'hffff);
      for (int ps = 0; ps < 4; ps++) begin
         ahb_wr(32'h00, 32'h8000 | (ps << 4));
         // The time base trails the count, so let the new ratio take over before sampling.
         repeat (2) @(posedge hclk);
         c0 = timebase_q.count_lo;
         repeat (512) @(posedge hclk);
         n = (512 >> sh[ps]);
         chk_rng({16'h0, timebase_q.count_lo - c0}, n - 1, n + 1);
      end
      $display("prescale done");
      ahb_wr(32'h00, 32'h8002);
      repeat (2) @(posedge hclk);
      c0 = timebase_q.count_lo;
      repeat (3) begin
         @(posedge hclk) ext_count_in[0] <= 1'b1;
         @(posedge hclk) ext_count_in[0] <= 1'b0;
      end
      repeat (4) @(posedge hclk);
      chk({16'h0, timebase_q.count_lo - c0}, 32'h3);
      ahb_wr(32'h00, 32'h8040);
      repeat (2) @(posedge hclk);
      c0 = timebase_q.count_lo;
      repeat (8) @(posedge hclk);
      chk({16'h0, timebase_q.count_lo - c0}, 32'h0);
      gate_in[0] <= 1'b1;
      repeat (5) @(posedge hclk);
      gate_in[0] <= 1'b0;
      repeat (4) @(posedge hclk);
      chk({16'h0, timebase_q.count_lo - c0}, 32'h5);
      $display("source and gate done");
      // A reset in mid-count must clear the outputs at once.
      hresetn <= 1'b0;
      #1;
      chk(timebase_q[31:0], 32'h0);
      chk({26'h0, hreadyout, irq_q, adc_trig_q, irq_level_q[1:0]}, 32'h20);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb_rd(32'h00, d);
      chk(d, 32'h0);
      $display("mid-run reset done");
      final_report;
   end
endmodule // tb
